// [core/stm_defs.vh]
// Constants for the sync timing monitor
`ifndef STM_DEFS_VH
`define STM_DEFS_VH

// ----------------------------------------
// Object indices and subindices
// ----------------------------------------
`define STM_IDX_OUT 16'h1c32
`define STM_IDX_IN 16'h1c33
`define STM_SUB_COUNT 8'h00
`define STM_SUB_MODE 8'h01
`define STM_SUB_CYCLE 8'h02
`define STM_SUB_SHIFT 8'h03
`define STM_SUB_SUPPORTED 8'h04
`define STM_SUB_MIN_CYCLE 8'h05
`define STM_SUB_CALC_COPY 8'h06
`define STM_SUB_MIN_DELAY 8'h07
`define STM_SUB_COMMAND 8'h08
`define STM_SUB_MAX_DELAY 8'h09
`define STM_SUB_MISSED 8'h0b
`define STM_SUB_EXCEEDED 8'h0c
`define STM_SUB_TOO_SHORT 8'h0d
`define STM_SUB_SYNC_ERR 8'h20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STM_RST_PARAM_COUNT 8'h20
`define STM_RST_OUT_MODE 16'h0001
`define STM_RST_IN_MODE 16'h0022
`define STM_RST_CYCLE 32'h000c65d4
`define STM_RST_MIN_CYCLE 32'h0000c350
`define STM_RST_SUPPORTED 16'hc007
`define STM_RST_COMMAND 16'h0000

// ----------------------------------------
// Sync mode codes and command values
// ----------------------------------------
`define STM_MODE_FREE_RUN 16'h0000
`define STM_MODE_SM_EVENT 16'h0001
`define STM_MODE_SYNC0 16'h0002
`define STM_MODE_SYNC1 16'h0003
`define STM_MODE_OUT_SM_EVENT 16'h0022
`define STM_CMD_STOP 16'h0000
`define STM_CMD_START 16'h0001

// ----------------------------------------
// Supported-modes bitmap fields
// ----------------------------------------
`define STM_SUP_FREE_RUN 0
`define STM_SUP_SM_EVENT 1
`define STM_SUP_DC_LSB 2
`define STM_SUP_SHIFT_LSB 4
`define STM_SUP_DYNAMIC 14
`define STM_SUP_DC_SUPPORTED 2'b01
`define STM_SUP_SHIFT_LOCAL 2'b01
`define STM_SUP_SHIFT_SYNC1 2'b10

// ----------------------------------------
// Timing
// ----------------------------------------
`define STM_CLK_PERIOD_NS 40
`define STM_CLK_NS_STEP 32'h00000028

`endif

// [core/stm_event_counter.v]
// Saturating 16-bit event counter with synchronous clear
`timescale 1ns/1ps
module stm_event_counter #(
    parameter WIDTH = 16
) (
    input wire core_clk,
    input wire reset_n,
    input wire clear,
    input wire event_hit,
    output reg [WIDTH-1:0] count
);

// ----------------------------------------
// Counter
// ----------------------------------------
// Saturates rather than wraps so a flood of errors never reads as few
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        count <= {WIDTH{1'b0}};
    end
    else if (clear)
    begin
        // Event on the clearing edge still counts
        count <= {{(WIDTH-1){1'b0}}, event_hit};
    end
    else if (event_hit && (count != {WIDTH{1'b1}}))
    begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
end

endmodule

// [core/stm_max_hold.v]
// Interval meter in ns that keeps the largest interval seen
`timescale 1ns/1ps
`include "stm_defs.vh"
module stm_max_hold #(
    parameter [31:0] RESET_VALUE = 32'h00000000
) (
    input wire core_clk,
    input wire reset_n,
    input wire enable,
    input wire clear,
    input wire start_pulse,
    input wire stop_pulse,
    output reg [31:0] max_ns
);

reg running;
reg [31:0] elapsed_ns;
wire [32:0] sum_ns;
wire [31:0] stop_ns;

assign sum_ns = {1'b0, elapsed_ns} + {1'b0, `STM_CLK_NS_STEP};
// Stop edge closes the last step, so pulses n cycles apart read 40n
assign stop_ns = sum_ns[32] ? elapsed_ns : sum_ns[31:0];

// ----------------------------------------
// Interval timer
// ----------------------------------------
// Counts in ns steps directly, so no multiplier is needed
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        running <= 1'b0;
        elapsed_ns <= 32'h00000000;
    end
    else if (!enable || clear)
    begin
        running <= 1'b0;
        elapsed_ns <= 32'h00000000;
    end
    else if (start_pulse)
    begin
        running <= 1'b1;
        elapsed_ns <= 32'h00000000;
    end
    else if (stop_pulse)
    begin
        running <= 1'b0;
    end
    else if (running && !sum_ns[32])
    begin
        elapsed_ns <= sum_ns[31:0];
    end
end

// ----------------------------------------
// Maximum capture
// ----------------------------------------
always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        max_ns <= RESET_VALUE;
    end
    else if (clear)
    begin
        max_ns <= 32'h00000000;
    end
    else if (enable && running && stop_pulse && !start_pulse && (stop_ns > max_ns))
    begin
        max_ns <= stop_ns;
    end
end

endmodule

// [core/stm_monitor.v]
// Sync manager timing monitor: parameter objects, measurement and error counters
`timescale 1ns/1ps
`include "stm_defs.vh"
module stm_monitor (
    input wire core_clk,
    input wire reset_n,
    input wire [15:0] obj_index,
    input wire [7:0] obj_subindex,
    input wire obj_write,
    input wire obj_read,
    input wire [31:0] obj_wdata,
    output reg [31:0] obj_rdata,
    output reg obj_rvalid,
    output reg obj_error,
    input wire operational,
    input wire sync0_event,
    input wire sync1_event,
    input wire sm_event,
    input wire cycle_start,
    input wire cycle_done,
    input wire copy_start,
    input wire copy_done,
    input wire input_sample,
    input wire output_latch,
    output wire dc_mode,
    output wire measuring,
    output reg sync_error
);

// ----------------------------------------
// Writable parameters
// ----------------------------------------
reg [15:0] measure_command;
reg [15:0] output_sync_mode;
reg [15:0] input_sync_mode;
reg [31:0] output_cycle_time;
reg [31:0] input_cycle_time;
reg operational_d;
reg sm_seen;
reg copy_busy;
reg cycle_busy;
reg cycle_fault;
wire is_out;
wire is_in;
wire known_obj;
wire wr_ok;
wire start_cmd;
wire meas_clear;
wire op_entry;
wire count_clear;
wire missed_hit;
wire exceeded_hit;
wire too_short_hit;
wire fault_now;
wire [15:0] supported_modes;
wire [31:0] output_min_cycle_time;
wire [31:0] output_calc_copy_time;
wire [31:0] output_max_delay_time;
wire [31:0] input_shift_time;
wire [15:0] missed_event_counter;
wire [15:0] cycle_exceeded_counter;
wire [15:0] shift_too_short_counter;

assign is_out = (obj_index == `STM_IDX_OUT);
assign is_in = (obj_index == `STM_IDX_IN);
assign start_cmd = obj_write && (is_out || is_in) && (obj_subindex == `STM_SUB_COMMAND)
    && (obj_wdata[15:0] == `STM_CMD_START);
assign measuring = (measure_command == `STM_CMD_START);
assign meas_clear = start_cmd;
assign op_entry = operational && !operational_d;
assign count_clear = op_entry;
assign dc_mode = (output_sync_mode == `STM_MODE_SYNC0) || (output_sync_mode == `STM_MODE_SYNC1)
    || (input_sync_mode == `STM_MODE_SYNC0) || (input_sync_mode == `STM_MODE_SYNC1);

// Bitmap is fixed; shift-source field stays 00 to match the reset value
assign supported_modes = (16'h0001 << `STM_SUP_FREE_RUN) | (16'h0001 << `STM_SUP_SM_EVENT)
    | ({14'h0000, `STM_SUP_DC_SUPPORTED} << `STM_SUP_DC_LSB)
    | (16'h0001 << `STM_SUP_DYNAMIC) | (16'h0001 << 15);

always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        measure_command <= `STM_RST_COMMAND;
        output_sync_mode <= `STM_RST_OUT_MODE;
        input_sync_mode <= `STM_RST_IN_MODE;
        output_cycle_time <= `STM_RST_CYCLE;
        input_cycle_time <= `STM_RST_CYCLE;
    end
    else if (obj_write)
    begin
        if ((is_out || is_in) && (obj_subindex == `STM_SUB_COMMAND))
        begin
            measure_command <= obj_wdata[15:0];
        end
        if (is_out && (obj_subindex == `STM_SUB_MODE))
        begin
            output_sync_mode <= obj_wdata[15:0];
        end
        if (is_in && (obj_subindex == `STM_SUB_MODE))
        begin
            input_sync_mode <= obj_wdata[15:0];
        end
        if (is_out && (obj_subindex == `STM_SUB_CYCLE))
        begin
            output_cycle_time <= obj_wdata;
        end
        if (is_in && (obj_subindex == `STM_SUB_CYCLE))
        begin
            input_cycle_time <= obj_wdata;
        end
    end
end

// ----------------------------------------
// Measured timing maxima
// ----------------------------------------
stm_max_hold #(.RESET_VALUE(`STM_RST_MIN_CYCLE)) u_min_cycle (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(measuring),
    .clear(meas_clear),
    .start_pulse(cycle_start),
    .stop_pulse(cycle_done),
    .max_ns(output_min_cycle_time)
);

stm_max_hold #(.RESET_VALUE(32'h00000000)) u_calc_copy (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(measuring),
    .clear(meas_clear),
    .start_pulse(copy_start),
    .stop_pulse(copy_done),
    .max_ns(output_calc_copy_time)
);

stm_max_hold #(.RESET_VALUE(32'h00000000)) u_max_delay (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(measuring),
    .clear(meas_clear),
    .start_pulse(sync1_event),
    .stop_pulse(output_latch),
    .max_ns(output_max_delay_time)
);

stm_max_hold #(.RESET_VALUE(32'h00000000)) u_in_shift (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .enable(measuring),
    .clear(meas_clear),
    .start_pulse(sync0_event),
    .stop_pulse(input_sample),
    .max_ns(input_shift_time)
);

// ----------------------------------------
// Cycle tracking
// ----------------------------------------
// In DC mode while operational, a SYNC0 with no SM event since the previous one means a missed event
assign missed_hit = operational && dc_mode && sync0_event && !sm_seen && !sm_event;
assign exceeded_hit = operational && cycle_start && cycle_busy;
assign too_short_hit = dc_mode && sync1_event && copy_busy;
assign fault_now = missed_hit || exceeded_hit || too_short_hit;

always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        operational_d <= 1'b0;
        sm_seen <= 1'b1;
        copy_busy <= 1'b0;
        cycle_busy <= 1'b0;
        cycle_fault <= 1'b0;
        sync_error <= 1'b0;
    end
    else
    begin
        operational_d <= operational;
        // Each SYNC0 opens a fresh window; a same-cycle SM event belongs to the old one
        if (sync0_event)
        begin
            sm_seen <= 1'b0;
        end
        else if (sm_event)
        begin
            sm_seen <= 1'b1;
        end
        if (copy_start)
        begin
            copy_busy <= 1'b1;
        end
        else if (copy_done)
        begin
            copy_busy <= 1'b0;
        end
        if (cycle_start)
        begin
            cycle_busy <= 1'b1;
        end
        else if (cycle_done)
        begin
            cycle_busy <= 1'b0;
        end
        // Flag reports the cycle just ended; events in the boundary cycle count
        if (op_entry)
        begin
            sync_error <= 1'b0;
            cycle_fault <= fault_now;
        end
        else if (cycle_start)
        begin
            sync_error <= cycle_fault || fault_now;
            cycle_fault <= 1'b0;
        end
        else if (fault_now)
        begin
            cycle_fault <= 1'b1;
        end
    end
end

// ----------------------------------------
// Error counters
// ----------------------------------------
stm_event_counter #(.WIDTH(16)) u_missed (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(count_clear),
    .event_hit(missed_hit),
    .count(missed_event_counter)
);

stm_event_counter #(.WIDTH(16)) u_exceeded (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(count_clear),
    .event_hit(exceeded_hit),
    .count(cycle_exceeded_counter)
);

stm_event_counter #(.WIDTH(16)) u_too_short (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(count_clear),
    .event_hit(too_short_hit),
    .count(shift_too_short_counter)
);

// ----------------------------------------
// Object read port
// ----------------------------------------
reg [31:0] next_rdata;
reg next_known;

always @*
begin
    next_rdata = 32'h00000000;
    next_known = 1'b1;
    case (obj_subindex)
        `STM_SUB_COUNT: next_rdata = {24'h000000, `STM_RST_PARAM_COUNT};
        `STM_SUB_MODE: next_rdata = is_out ? {16'h0000, output_sync_mode}
            : {16'h0000, input_sync_mode};
        `STM_SUB_CYCLE: next_rdata = is_out ? output_cycle_time : input_cycle_time;
        `STM_SUB_SHIFT: next_rdata = is_out ? 32'h00000000 : input_shift_time;
        `STM_SUB_SUPPORTED: next_rdata = {16'h0000, supported_modes};
        `STM_SUB_MIN_CYCLE: next_rdata = output_min_cycle_time;
        `STM_SUB_CALC_COPY: next_rdata = is_out ? output_calc_copy_time : 32'h00000000;
        `STM_SUB_MIN_DELAY: next_rdata = 32'h00000000;
        `STM_SUB_COMMAND: next_rdata = {16'h0000, measure_command};
        `STM_SUB_MAX_DELAY: next_rdata = is_out ? output_max_delay_time : 32'h00000000;
        `STM_SUB_MISSED: next_rdata = {16'h0000, missed_event_counter};
        `STM_SUB_EXCEEDED: next_rdata = {16'h0000, cycle_exceeded_counter};
        `STM_SUB_TOO_SHORT: next_rdata = {16'h0000, shift_too_short_counter};
        `STM_SUB_SYNC_ERR: next_rdata = {31'h00000000, sync_error};
        default: next_known = 1'b0;
    endcase
end

assign known_obj = (is_out || is_in) && next_known;
// Only mode, cycle time and command accept writes; others are read-only
assign wr_ok = known_obj && ((obj_subindex == `STM_SUB_MODE)
    || (obj_subindex == `STM_SUB_CYCLE) || (obj_subindex == `STM_SUB_COMMAND));

always @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        obj_rdata <= 32'h00000000;
        obj_rvalid <= 1'b0;
        obj_error <= 1'b0;
    end
    else
    begin
        obj_rvalid <= obj_read && !obj_write;
        obj_error <= (obj_read && !obj_write && !known_obj) || (obj_write && !wr_ok);
        if (obj_read && !obj_write)
        begin
            obj_rdata <= known_obj ? next_rdata : 32'h00000000;
        end
    end
end

endmodule

// [test/stm_monitor_properties.sv]
// Concurrent checks on the sync timing monitor ports
`timescale 1ns/1ps
module stm_monitor_checker (
    input wire core_clk,
    input wire reset_n,
    input wire [15:0] obj_index,
    input wire [7:0] obj_subindex,
    input wire obj_write,
    input wire obj_read,
    input wire [31:0] obj_wdata,
    input wire [31:0] obj_rdata,
    input wire obj_rvalid,
    input wire obj_error,
    input wire operational,
    input wire cycle_start,
    input wire dc_mode,
    input wire measuring,
    input wire sync_error
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    wire known = obj_index == 16'h1c32 || obj_index == 16'h1c33;
    wire rd_q = obj_read && !obj_write && known;
    wire wr_q = obj_write && known;
    wire cmd_wr = wr_q && obj_subindex == 8'h08;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_cmd_start: assert property (cmd_wr && obj_wdata[15:0] == 16'h0001 |=> measuring)
        else $error("start command did not start measuring");
    chk_cmd_stop: assert property (cmd_wr && obj_wdata[15:0] == 16'h0000 |=> !measuring)
        else $error("stop command did not stop measuring");
    chk_cmd_hold: assert property (!obj_write |=> $stable(measuring))
        else $error("measuring changed without a write");
    chk_modes_read: assert property (rd_q && obj_subindex == 8'h04 |=>
        obj_rvalid && obj_rdata == 32'h0000c007)
        else $error("supported modes read wrong");
    chk_min_cycle_ro: assert property (wr_q && obj_subindex == 8'h05 |=> obj_error)
        else $error("write to minimum cycle time not refused");
    chk_sync0_mode: assert property (wr_q && obj_subindex == 8'h01 &&
        obj_wdata[15:0] == 16'h0002 |=> dc_mode)
        else $error("sync0 mode did not select distributed clock");
    // Flag may only move on a cycle start once the state has settled
    chk_flag_steady: assert property (!cycle_start && operational && $past(operational) &&
        $past(operational, 2) |=> $stable(sync_error))
        else $error("sync error moved outside a cycle start");
    chk_flag_clear: assert property ($rose(operational) && !cycle_start ##1 !cycle_start
        |=> !sync_error)
        else $error("sync error not cleared on operational entry");
    cover property (cmd_wr && obj_wdata[15:0] == 16'h0001);
    cover property ($rose(sync_error));
    cover property (dc_mode && measuring);
endmodule

bind stm_monitor stm_monitor_checker i_chk (.core_clk(core_clk), .reset_n(reset_n),
    .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_write(obj_write),
    .obj_read(obj_read), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_rvalid(obj_rvalid), .obj_error(obj_error), .operational(operational),
    .cycle_start(cycle_start), .dc_mode(dc_mode), .measuring(measuring),
    .sync_error(sync_error));

// [test/stm_master_model.sv]
// Bus master model issuing cycle, copy and sync event pulses
`timescale 1ns/1ps
module stm_master_model (
    input wire core_clk,
    output wire sync0_event,
    output wire sync1_event,
    output wire sm_event,
    output wire cycle_start,
    output wire cycle_done,
    output wire copy_start,
    output wire copy_done,
    output wire input_sample,
    output wire output_latch
);
    // ----------------------------------------
    // Event pulses
    // ----------------------------------------
    reg [8:0] ev = 9'h000;
    assign {sync0_event, sync1_event, sm_event, cycle_start, cycle_done, copy_start,
        copy_done, input_sample, output_latch} = ev;
    // Idle low between pulses, never a held level
    task pulse(input [8:0] m);
    begin
        @(negedge core_clk);
        ev = m;
        @(negedge core_clk);
        ev = 9'h000;
    end
    endtask
    // Second pulse sampled n edges after the first, n at least 2
    task span(input [8:0] a, input [8:0] b, input integer n);
    begin
        pulse(a);
        repeat (n - 2) @(negedge core_clk);
        pulse(b);
    end
    endtask
endmodule

// [test/test_stm_monitor.sv]
// Bench for the sync timing monitor object port and event counters
`timescale 1ns/1ps
module test_stm_monitor;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    reg core_clk = 1'b0;
    reg reset_n = 1'b0;
    reg [15:0] obj_index = 16'h0000;
    reg [7:0] obj_subindex = 8'h00;
    reg obj_write = 1'b0;
    reg obj_read = 1'b0;
    reg [31:0] obj_wdata = 32'h00000000;
    reg operational = 1'b0;
    wire [31:0] obj_rdata;
    wire obj_rvalid, obj_error, dc_mode, measuring, sync_error;
    wire s0, s1, sm, cs, cd, ps, pd, isp, ol;
    reg [31:0] rd_data;
    reg rd_v, wr_err;
    integer fails = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    integer k;
    localparam [15:0] io = 16'h1c32;
    localparam [15:0] ii = 16'h1c33;
    localparam [8:0] m_s0 = 9'h100, m_s1 = 9'h080, m_sm = 9'h040, m_cs = 9'h020;
    localparam [8:0] m_cd = 9'h010, m_ps = 9'h008, m_pd = 9'h004, m_is = 9'h002;
    localparam [8:0] m_ol = 9'h001;

    stm_monitor i_dut (.core_clk(core_clk), .reset_n(reset_n), .obj_index(obj_index),
        .obj_subindex(obj_subindex), .obj_write(obj_write), .obj_read(obj_read),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_rvalid(obj_rvalid),
        .obj_error(obj_error), .operational(operational), .sync0_event(s0),
        .sync1_event(s1), .sm_event(sm), .cycle_start(cs), .cycle_done(cd),
        .copy_start(ps), .copy_done(pd), .input_sample(isp), .output_latch(ol),
        .dc_mode(dc_mode), .measuring(measuring), .sync_error(sync_error));
    stm_master_model i_mst (.core_clk(core_clk), .sync0_event(s0), .sync1_event(s1),
        .sm_event(sm), .cycle_start(cs), .cycle_done(cd), .copy_start(ps),
        .copy_done(pd), .input_sample(isp), .output_latch(ol));

    // ----------------------------------------
    // Clock, timeout and tasks
    // ----------------------------------------
    initial
    begin
        forever #20 core_clk = ~core_clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 3000)
        begin
            fails = fails + 1;
            final_report;
        end
    end
    task chk(input string n, input [31:0] seen, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    end
    endtask
    task rd(input [15:0] i, input [7:0] s);
    begin
        @(negedge core_clk);
        obj_index = i;
        obj_subindex = s;
        obj_read = 1'b1;
        @(negedge core_clk);
        obj_read = 1'b0;
        rd_data = obj_rdata;
        rd_v = obj_rvalid;
    end
    endtask
    task wr(input [15:0] i, input [7:0] s, input [31:0] d);
    begin
        @(negedge core_clk);
        obj_index = i;
        obj_subindex = s;
        obj_wdata = d;
        obj_write = 1'b1;
        @(negedge core_clk);
        obj_write = 1'b0;
        wr_err = obj_error;
    end
    endtask
    task rc(input [15:0] i, input [7:0] s, input [31:0] e);
    begin
        rd(i, s);
        chk("rvalid", {31'h00000000, rd_v}, 32'h00000001);
        chk("rdata", rd_data, e);
    end
    endtask
    task final_report;
    begin
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        rc(io, 8'h00, 32'h00000020);
        rc(io, 8'h01, 32'h00000001);
        rc(ii, 8'h01, 32'h00000022);
        rc(ii, 8'h02, 32'h000c65d4);
        rc(ii, 8'h04, 32'h0000c007);
        rc(io, 8'h05, 32'h0000c350);
        rc(ii, 8'h03, 32'h00000000);
        rc(io, 8'h08, 32'h00000000);
        for (k = 11; k < 14; k = k + 1)
            rc(ii, k, 32'h00000000);
        rc(io, 8'h20, 32'h00000000);
        wr(io, 8'h05, 32'h00000001);
        chk("ro refused", {31'h00000000, wr_err}, 32'h00000001);
        rc(io, 8'h05, 32'h0000c350);
        $display("test reset and read-only done");
        for (k = 0; k < 5; k = k + 1)
        begin
            wr(ii, 8'h01, (k == 4) ? 32'h00000022 : k);
            rc(ii, 8'h01, (k == 4) ? 32'h00000022 : k);
        end
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(io, 8'h01, k);
            rc(io, 8'h01, k);
        end
        wr(io, 8'h01, 32'h00000003);
        chk("dc on", {31'h00000000, dc_mode}, 32'h00000001);
        wr(io, 8'h01, 32'h00000000);
        chk("dc off", {31'h00000000, dc_mode}, 32'h00000000);
        wr(ii, 8'h01, 32'h00000002);
        // Shortest cycle the master may configure
        wr(io, 8'h02, 32'h0000c350);
        rc(io, 8'h02, 32'h0000c350);
        $display("test modes done");
        wr(io, 8'h08, 32'h00000001);
        chk("measuring", {31'h00000000, measuring}, 32'h00000001);
        i_mst.span(m_cs, m_cd, 5);
        i_mst.span(m_ps, m_pd, 4);
        i_mst.span(m_s1, m_ol, 3);
        i_mst.span(m_s0, m_is, 6);
        i_mst.span(m_cs, m_cd, 2);
        rc(io, 8'h05, 32'h000000c8);
        rc(io, 8'h06, 32'h000000a0);
        rc(io, 8'h09, 32'h00000078);
        rc(ii, 8'h03, 32'h000000f0);
        wr(io, 8'h08, 32'h00000000);
        chk("stopped", {31'h00000000, measuring}, 32'h00000000);
        i_mst.span(m_cs, m_cd, 7);
        rc(ii, 8'h05, 32'h000000c8);
        wr(ii, 8'h08, 32'h00000001);
        rc(io, 8'h06, 32'h00000000);
        i_mst.span(m_cs, m_cd, 3);
        rc(io, 8'h05, 32'h00000078);
        wr(io, 8'h08, 32'h00000000);
        $display("test measurement done");
        operational = 1'b1;
        repeat (3) @(negedge core_clk);
        i_mst.pulse(m_s0 | m_sm);
        i_mst.pulse(m_s0);
        i_mst.pulse(m_cs);
        i_mst.pulse(m_cs);
        i_mst.pulse(m_cd);
        i_mst.pulse(m_ps);
        i_mst.pulse(m_s1);
        i_mst.pulse(m_pd);
        i_mst.pulse(m_cs);
        chk("sync error", {31'h00000000, sync_error}, 32'h00000001);
        rc(io, 8'h0b, 32'h00000001);
        rc(ii, 8'h0c, 32'h00000001);
        rc(io, 8'h0d, 32'h00000001);
        rc(ii, 8'h20, 32'h00000001);
        i_mst.pulse(m_cd);
        i_mst.pulse(m_cs);
        chk("sync clean", {31'h00000000, sync_error}, 32'h00000000);
        i_mst.pulse(m_cd);
        wr(ii, 8'h01, 32'h00000000);
        i_mst.pulse(m_s0);
        i_mst.pulse(m_s0);
        i_mst.pulse(m_ps);
        i_mst.pulse(m_s1);
        i_mst.pulse(m_pd);
        rc(io, 8'h0b, 32'h00000001);
        rc(io, 8'h0d, 32'h00000001);
        i_mst.pulse(m_cs);
        i_mst.pulse(m_cs);
        chk("sync error set", {31'h00000000, sync_error}, 32'h00000001);
        operational = 1'b0;
        @(negedge core_clk);
        operational = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("flag cleared", {31'h00000000, sync_error}, 32'h00000000);
        for (k = 11; k < 14; k = k + 1)
            rc(io, k, 32'h00000000);
        $display("test counters done");
        final_report;
    end
endmodule
